// file: chs_sense_masks.v
// Summary of operation
// - battery bit 6 shows over-voltage comparator
// - battery bit 4 shows weak-battery reconnect comparator
// - battery bit 1 shows charge current above end-of-charge
// - temperature bit 3 shows thermal shutdown comparator
// - temperature bit 2 shows second modulation level
// - temperature bit 1 shows first modulation level
// - temperature bit 0 shows thermal warning level
// - status mask bits 5..2 thermal, reset 0
// - status mask bit 0 input-valid, also cleared on boost
// - mask one bits 4,3 input low/high, reset 0
// - mask one bit 1 battery over-voltage, reset 0
// - mask one bit 0 state change, reset 0
// - mask two bits 3..1 timeouts, reset 1
// - watchdog flag set at 32 s, read-clear
`timescale 1ns/1ps
`include "chs_map.vh"
module chs_sense_masks #(
  parameter [6:0]  I2C_ADDR    = `CHS_I2C_ADDR,
  parameter [31:0] WDOG_CYCLES = `CHS_WDOG_TIME_S * `CHS_CLK_HZ
) (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  // serial control bus pins
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe,
  // analog comparator levels
  input  wire       battery_overvoltage_sense,
  input  wire       recharge_level_sense,
  input  wire       weak_battery_sense,
  input  wire       precharge_level_sense,
  input  wire       safe_level_sense,
  input  wire       end_of_charge_current_sense,
  input  wire       thermal_shutdown_sense,
  input  wire       thermal_level_two_sense,
  input  wire       thermal_level_one_sense,
  input  wire       thermal_warning_sense,
  // reset events from the charger core
  input  wire       off_state,
  input  wire       reg_reset,
  input  wire       boost_output_mode,
  // latched interrupt flags from the charger core, aligned to mask bits
  input  wire [7:0] stat_irq_flags,
  input  wire [7:0] ch1_irq_flags,
  input  wire [7:0] ch2_irq_flags,
  // watchdog run enable
  input  wire       wdog_enable,
  // interrupt out
  output reg        irq
);

  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_ACKA = 9'h004;
  localparam [8:0] S_REG  = 9'h008;
  localparam [8:0] S_ACKR = 9'h010;
  localparam [8:0] S_WDAT = 9'h020;
  localparam [8:0] S_ACKW = 9'h040;
  localparam [8:0] S_RDAT = 9'h080;
  localparam [8:0] S_RACK = 9'h100;

  wire [11:0] sync_q;
  reg         scl_q_r;
  reg         sda_q_r;
  reg  [8:0]  st_r;
  reg  [3:0]  cnt_r;
  reg  [7:0]  sh_r;
  reg  [7:0]  tx_r;
  reg  [7:0]  ptr_r;
  reg         rw_r;
  reg         nack_r;
  reg         wr_stb_r;
  reg  [7:0]  wr_addr_r;
  reg  [7:0]  wr_data_r;
  reg         rd_stb_r;
  reg  [7:0]  rd_addr_r;
  reg  [7:0]  status_interrupt_mask_r;
  reg  [7:0]  charger_interrupt_mask_one_r;
  reg  [7:0]  charger_interrupt_mask_two_r;
  reg         wdog_flag_r;
  reg         otg_q_r;
  reg  [7:0]  batt_sns;
  reg  [7:0]  die_temperature_sense;
  reg  [7:0]  rd_data;
  wire        wdog_expire;

  // pins and comparators pass two flops
  chs_sync #(
    .W    (12),
    .INIT (12'hc00)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({scl_i, sda_i,
            battery_overvoltage_sense, recharge_level_sense,
            weak_battery_sense, precharge_level_sense,
            safe_level_sense, end_of_charge_current_sense,
            thermal_shutdown_sense, thermal_level_two_sense,
            thermal_level_one_sense, thermal_warning_sense}),
    .q    (sync_q)
  );

  wire scl_s     = sync_q[11];
  wire sda_s     = sync_q[10];
  wire scl_rise  = scl_s & ~scl_q_r;
  wire scl_fall  = ~scl_s & scl_q_r;
  wire bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  wire bus_stop  = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // live comparator images, reserved bits zero
  always @* begin
    batt_sns = 8'h00;
    die_temperature_sense = 8'h00;
    batt_sns[`CHS_BIT_BATT_OV] = sync_q[9];
    batt_sns[`CHS_BIT_RECHG]   = sync_q[8];
    batt_sns[`CHS_BIT_WEAK]    = sync_q[7];
    batt_sns[`CHS_BIT_PRECHG]  = sync_q[6];
    batt_sns[`CHS_BIT_SAFE]    = sync_q[5];
    batt_sns[`CHS_BIT_EOC]     = sync_q[4];
    die_temperature_sense[`CHS_BIT_TSD]     = sync_q[3];
    die_temperature_sense[`CHS_BIT_TM2]     = sync_q[2];
    die_temperature_sense[`CHS_BIT_TM1]     = sync_q[1];
    die_temperature_sense[`CHS_BIT_TWARN]   = sync_q[0];
  end

  // read mux, unmapped offsets read zero
  always @* begin
    case (ptr_r)
      `CHS_OFS_WDOG_FLAGS: rd_data = {4'h0, wdog_flag_r, 3'h0};
      `CHS_OFS_BATT_SENSE: rd_data = batt_sns;
      `CHS_OFS_TEMP_SENSE: rd_data = die_temperature_sense;
      `CHS_OFS_STAT_MASK:  rd_data = status_interrupt_mask_r;
      `CHS_OFS_CH1_MASK:   rd_data = charger_interrupt_mask_one_r;
      `CHS_OFS_CH2_MASK:   rd_data = charger_interrupt_mask_two_r;
      default:             rd_data = 8'h00;
    endcase
  end

  // serial control bus slave: address, register pointer, data, auto-increment
  always @(posedge clk) begin
    if (srst) begin
      scl_q_r   <= 1'b1;
      sda_q_r   <= 1'b1;
      st_r      <= S_IDLE;
      cnt_r     <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      rd_stb_r  <= 1'b0;
      rd_addr_r <= 8'h00;
      sda_o     <= 1'b0;
      sda_oe    <= 1'b0;
    end else begin
      scl_q_r  <= scl_s;
      sda_q_r  <= sda_s;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      sda_o    <= 1'b0;
      if (bus_start) begin
        st_r   <= S_ADDR;
        cnt_r  <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        st_r   <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_r)
          S_ADDR: begin
            if (scl_rise) begin
              sh_r  <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              if (sh_r[7:1] == I2C_ADDR) begin
                sda_oe <= 1'b1;
                rw_r   <= sh_r[0];
                st_r   <= S_ACKA;
              end else begin
                st_r <= S_IDLE;
              end
            end
          end
          S_ACKA, S_RACK: begin
            if (scl_rise) begin
              nack_r <= sda_s & st_r[8];
            end else if (scl_fall) begin
              cnt_r <= 4'h0;
              if (st_r[8] && nack_r) begin
                sda_oe <= 1'b0;
                st_r   <= S_IDLE;
              end else if (st_r[8] || rw_r) begin
                tx_r      <= rd_data;
                rd_stb_r  <= 1'b1;
                rd_addr_r <= ptr_r;
                ptr_r     <= ptr_r + 8'h01;
                sda_oe    <= ~rd_data[7];
                st_r      <= S_RDAT;
              end else begin
                sda_oe <= 1'b0;
                st_r   <= S_REG;
              end
            end
          end
          S_REG: begin
            if (scl_rise) begin
              sh_r  <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              ptr_r  <= sh_r;
              sda_oe <= 1'b1;
              st_r   <= S_ACKR;
            end
          end
          S_ACKR, S_ACKW: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              cnt_r  <= 4'h0;
              st_r   <= S_WDAT;
            end
          end
          S_WDAT: begin
            if (scl_rise) begin
              sh_r  <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              wr_stb_r  <= 1'b1;
              wr_addr_r <= ptr_r;
              wr_data_r <= sh_r;
              ptr_r     <= ptr_r + 8'h01;
              sda_oe    <= 1'b1;
              st_r      <= S_ACKW;
            end
          end
          S_RDAT: begin
            if (scl_fall) begin
              if (cnt_r == 4'h7) begin
                sda_oe <= 1'b0;
                nack_r <= 1'b0;
                st_r   <= S_RACK;
              end else begin
                tx_r   <= {tx_r[6:0], 1'b0};
                sda_oe <= ~tx_r[6];
                cnt_r  <= cnt_r + 4'h1;
              end
            end
          end
          default: begin
            st_r   <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  wire otg_entry = boost_output_mode & ~otg_q_r;
  wire clr_all   = off_state | reg_reset;

  // mask registers; a reset event in the same cycle beats a write
  always @(posedge clk) begin
    if (srst) begin
      otg_q_r <= 1'b0;
    end else begin
      otg_q_r <= boost_output_mode;
    end
    if (srst || clr_all) begin
      status_interrupt_mask_r <= `CHS_STAT_RST;
    end else if (otg_entry) begin
      status_interrupt_mask_r <= status_interrupt_mask_r & ~`CHS_STAT_OTG_CLR;
    end else if (wr_stb_r && wr_addr_r == `CHS_OFS_STAT_MASK) begin
      status_interrupt_mask_r <= wr_data_r & `CHS_STAT_WMASK;
    end
    if (srst || clr_all || otg_entry) begin
      charger_interrupt_mask_one_r <= `CHS_CH1_RST;
      charger_interrupt_mask_two_r <= `CHS_CH2_RST;
    end else if (wr_stb_r) begin
      if (wr_addr_r == `CHS_OFS_CH1_MASK) begin
        charger_interrupt_mask_one_r <= wr_data_r & `CHS_CH1_WMASK;
      end
      if (wr_addr_r == `CHS_OFS_CH2_MASK) begin
        charger_interrupt_mask_two_r <= wr_data_r & `CHS_CH2_WMASK;
      end
    end
  end

  // watchdog restarts on every data byte written or read, not on address or register pointer bytes
  chs_wdog #(
    .CYCLES (WDOG_CYCLES)
  ) u_wdog (
    .clk    (clk),
    .srst   (srst),
    .enable (wdog_enable),
    .kick   (wr_stb_r | rd_stb_r),
    .expire (wdog_expire)
  );

  // expiry flag: set wins over the read-clear
  always @(posedge clk) begin
    if (srst || clr_all || otg_entry) begin
      wdog_flag_r <= 1'b0;
    end else if (wdog_expire) begin
      wdog_flag_r <= 1'b1;
    end else if (rd_stb_r && rd_addr_r == `CHS_OFS_WDOG_FLAGS) begin
      wdog_flag_r <= 1'b0;
    end
  end

  // flags latch regardless of mask; a set mask bit only blocks the output
  wire [7:0] ch2_all = (ch2_irq_flags & ~(8'h01 << `CHS_BIT_WDOG_FLAG))
                       | ({7'h00, wdog_flag_r} << `CHS_BIT_WDOG_FLAG);
  wire       irq_pend = |(stat_irq_flags & ~status_interrupt_mask_r & `CHS_STAT_WMASK)
                      | |(ch1_irq_flags & ~charger_interrupt_mask_one_r & `CHS_CH1_WMASK)
                      | |(ch2_all & ~charger_interrupt_mask_two_r & `CHS_CH2_WMASK);

  always @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_pend;
    end
  end

endmodule

// file: chs_map.vh
`ifndef CHS_MAP_VH
`define CHS_MAP_VH

// register offsets
`define CHS_OFS_WDOG_FLAGS  8'h05
`define CHS_OFS_BATT_SENSE  8'h08
`define CHS_OFS_TEMP_SENSE  8'h09
`define CHS_OFS_STAT_MASK   8'h0a
`define CHS_OFS_CH1_MASK    8'h0b
`define CHS_OFS_CH2_MASK    8'h0c

// battery_comparator_sense fields
`define CHS_BIT_BATT_OV     6
`define CHS_BIT_RECHG       5
`define CHS_BIT_WEAK        4
`define CHS_BIT_PRECHG      3
`define CHS_BIT_SAFE        2
`define CHS_BIT_EOC         1

// die_temperature_sense fields
`define CHS_BIT_TSD         3
`define CHS_BIT_TM2         2
`define CHS_BIT_TM1         1
`define CHS_BIT_TWARN       0

// status_interrupt_mask fields
`define CHS_BIT_TWARN_MSK   5
`define CHS_BIT_TM1_MSK     4
`define CHS_BIT_TM2_MSK     3
`define CHS_BIT_TSD_MSK     2
`define CHS_BIT_VALID_MSK   0

// charger_interrupt_mask_one fields
`define CHS_BIT_VINLO_MSK   4
`define CHS_BIT_VINHI_MSK   3
`define CHS_BIT_BOVP_MSK    1
`define CHS_BIT_STCHG_MSK   0

// charger_interrupt_mask_two fields, same positions as the flags at 0x05
`define CHS_BIT_WDOG_MSK    3
`define CHS_BIT_USBTO_MSK   2
`define CHS_BIT_CHGTO_MSK   1
`define CHS_BIT_WDOG_FLAG   3

// writable bits and reset values
`define CHS_STAT_WMASK      8'h3d
`define CHS_CH1_WMASK       8'h1b
`define CHS_CH2_WMASK       8'h0e
`define CHS_STAT_RST        8'h00
`define CHS_CH1_RST         8'h00
`define CHS_CH2_RST         8'h0e
`define CHS_STAT_OTG_CLR    8'h01

// timing
`define CHS_CLK_HZ          50000000
`define CHS_WDOG_TIME_S     32
`define CHS_I2C_ADDR        7'h36

`endif

// file: chs_sync.v
`timescale 1ns/1ps
module chs_sync #(
  parameter         W    = 1,
  // reset level, set to the idle level of each pin to avoid a false edge
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input  wire         clk,
  input  wire         srst,
  // asynchronous levels in, synchronised levels out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_r;

  always @(posedge clk) begin
    if (srst) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// file: chs_wdog.v
`timescale 1ns/1ps
module chs_wdog #(
  parameter [31:0] CYCLES = 32'd1600000000
) (
  // clock and reset
  input  wire clk,
  input  wire srst,
  // control
  input  wire enable,
  input  wire kick,
  // one-cycle pulse when the period runs out
  output reg  expire
);

  reg [31:0] cnt_r;

  always @(posedge clk) begin
    if (srst) begin
      cnt_r  <= 32'h00000000;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (!enable || kick) begin
        cnt_r <= 32'h00000000;
      end else if (cnt_r == CYCLES - 32'd1) begin
        cnt_r  <= 32'h00000000;
        expire <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 32'd1;
      end
    end
  end

endmodule

// file: chs_sense_masks_sva.sv
`timescale 1ns/1ps
module chs_sense_masks_sva (
  // clock and reset
  input wire       clk,
  input wire       srst,
  // outputs watched
  input wire       sda_o,
  input wire       sda_oe,
  input wire       irq,
  // reset events and flags
  input wire       off_state,
  input wire       reg_reset,
  input wire       boost_output_mode,
  input wire [7:0] stat_irq_flags,
  input wire [7:0] ch1_irq_flags,
  input wire [7:0] ch2_irq_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // an event clears the mask, so a raised flag must reach irq
  property p_off(f);
    (off_state && f) [*3] |=> irq;
  endproperty
  property p_otg(f);
    $rose(boost_output_mode) && f ##1 f [*2] |=> irq;
  endproperty
  a_rst_idle: assert property (disable iff (1'b0) srst |=> !sda_oe && !sda_o && !irq)
    else $error("bus or irq active after reset");
  a_off_thermal: assert property (p_off(stat_irq_flags[5:2] != 4'h0))
    else $error("thermal mask not cleared by off state");
  a_off_charger: assert property (p_off((ch1_irq_flags & 8'h1b) != 8'h00))
    else $error("charger mask not cleared by off state");
  a_otg_valid: assert property (p_otg(stat_irq_flags[0]))
    else $error("input valid mask not cleared on boost entry");
  a_otg_input: assert property (p_otg(ch1_irq_flags[4:3] != 2'h0))
    else $error("input level masks not cleared on boost entry");
  a_otg_bovp: assert property (p_otg(ch1_irq_flags[1]))
    else $error("over-voltage mask not cleared on boost entry");
  a_otg_stchg: assert property (p_otg(ch1_irq_flags[0]))
    else $error("state change mask not cleared on boost entry");
  a_ch2_dflt: assert property ((reg_reset && ch2_irq_flags[2:1] != 2'h0 &&
      stat_irq_flags == 8'h00 && ch1_irq_flags == 8'h00) [*3] |=> !irq)
    else $error("timeout masks not set by register reset");
  c_ack: cover property (sda_oe ##1 !sda_oe);
  c_otg: cover property ($rose(boost_output_mode));
  c_irq: cover property ($rose(irq));
endmodule

bind chs_sense_masks chs_sense_masks_sva u_chs_sense_masks_sva (
  .clk(clk), .srst(srst), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq),
  .off_state(off_state), .reg_reset(reg_reset), .boost_output_mode(boost_output_mode),
  .stat_irq_flags(stat_irq_flags), .ch1_irq_flags(ch1_irq_flags),
  .ch2_irq_flags(ch2_irq_flags));

// file: chs_host.sv
`timescale 1ns/1ps
module chs_host #(
  parameter [6:0] ADDR = 7'h36
) (
  // clock
  input  wire clk,
  // resolved data line and host drives
  input  wire sda,
  output reg  scl,
  output reg  sda_pull
);
  reg       ack;
  reg [7:0] q;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task ph(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // data moves only mid low phase, away from the scl edges
  task bitx(input b, output r);
    begin
      ph(4);
      sda_pull = !b;
      ph(4);
      scl = 1'b1;
      ph(8);
      r = sda;
      scl = 1'b0;
    end
  endtask
  task xfer(input [7:0] d, input last, output [7:0] o, output nak);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bitx(d[i], o[i]);
      bitx(last, nak);
    end
  endtask
  // also serves as repeated start
  task start;
    begin
      ph(4);
      sda_pull = 1'b0;
      ph(4);
      scl = 1'b1;
      ph(8);
      sda_pull = 1'b1;
      ph(8);
      scl = 1'b0;
    end
  endtask
  task stop;
    begin
      ph(4);
      sda_pull = 1'b1;
      ph(4);
      scl = 1'b1;
      ph(8);
      sda_pull = 1'b0;
      ph(8);
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d, output nak);
    begin
      start;
      xfer({ADDR, 1'b0}, 1'b1, q, nak);
      xfer(a, 1'b1, q, ack);
      xfer(d, 1'b1, q, ack);
      stop;
    end
  endtask
  task rd_reg(input [7:0] a, output [7:0] d);
    begin
      start;
      xfer({ADDR, 1'b0}, 1'b1, q, ack);
      xfer(a, 1'b1, q, ack);
      start;
      xfer({ADDR, 1'b1}, 1'b1, q, ack);
      xfer(8'hff, 1'b1, d, ack);
      stop;
    end
  endtask
endmodule

// file: test_chs_sense_masks.sv
`timescale 1ns/1ps
module test_chs_sense_masks;
  localparam [47:0] OFS = 48'h08090a0b0c20;
  localparam [47:0] RV  = 48'h000000000e00;
  localparam [47:0] FV  = 48'h00003d1b0e00;
  reg        clk, srst, off_state, reg_reset, boost_output_mode, wdog_enable;
  reg  [9:0] sv;
  reg  [7:0] sf, c1f, c2f, got;
  reg        nak;
  wire       scl, sda_pull, sda_o, sda_oe, irq;
  // pull-up line, both sides open drain
  wire       sda = !(sda_pull | sda_oe);
  integer    n_fail, n_compared, i, k;
  chs_sense_masks #(.WDOG_CYCLES(32'd200)) u_chs_sense_masks (
    .clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .battery_overvoltage_sense(sv[5]), .recharge_level_sense(sv[4]),
    .weak_battery_sense(sv[3]), .precharge_level_sense(sv[2]),
    .safe_level_sense(sv[1]), .end_of_charge_current_sense(sv[0]),
    .thermal_shutdown_sense(sv[9]), .thermal_level_two_sense(sv[8]),
    .thermal_level_one_sense(sv[7]), .thermal_warning_sense(sv[6]),
    .off_state(off_state), .reg_reset(reg_reset), .boost_output_mode(boost_output_mode),
    .stat_irq_flags(sf), .ch1_irq_flags(c1f), .ch2_irq_flags(c2f),
    .wdog_enable(wdog_enable), .irq(irq));
  chs_host u_chs_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      u_chs_host.rd_reg(a, got);
      chk($sformatf("reg %h", a), e, got);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      u_chs_host.wr_reg(a, d, nak);
      chk("address ack", 8'h00, {7'h0, nak});
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    {srst, off_state, reg_reset, boost_output_mode, wdog_enable} = 5'h10;
    {sv, sf, c1f, c2f} = 34'h0;
    n_fail = 0;
    n_compared = 0;
    cyc(5);
    srst = 1'b0;
    cyc(4);
    for (i = 0; i < 6; i = i + 1) rd(OFS[47-8*i -: 8], RV[47-8*i -: 8]);
    for (i = 0; i < 10; i = i + 1) begin
      sv = 10'h1 << i;
      rd(8'h08, {1'b0, sv[5:0], 1'b0});
      rd(8'h09, {4'h0, sv[9:6]});
    end
    sv = 10'h0;
    for (i = 0; i < 6; i = i + 1) wr(OFS[47-8*i -: 8], 8'hff);
    for (i = 0; i < 6; i = i + 1) rd(OFS[47-8*i -: 8], FV[47-8*i -: 8]);
    {sf, c1f, c2f} = 24'h3d1b06;
    cyc(3);
    chk("irq", 8'h00, {7'h0, irq});
    wr(8'h0a, 8'h00);
    chk("irq", 8'h01, {7'h0, irq});
    for (k = 0; k < 3; k = k + 1) begin
      wr(8'h0a, 8'hff);
      wr(8'h0b, 8'hff);
      wr(8'h0c, 8'h00);
      sf = (k == 2) ? 8'h00 : 8'h3d;
      c1f = (k == 2) ? 8'h00 : 8'h1b;
      c2f = (k == 2) ? 8'h06 : 8'h00;
      {boost_output_mode, off_state, reg_reset} = 3'b100 >> k;
      cyc(4);
      {off_state, reg_reset} = 2'b00;
      cyc(2);
      chk("irq", (k == 2) ? 8'h00 : 8'h01, {7'h0, irq});
      {sf, c1f, c2f} = 24'h0;
      rd(8'h0a, (k == 0) ? 8'h3c : 8'h00);
      rd(8'h0b, 8'h00);
      rd(8'h0c, 8'h0e);
    end
    boost_output_mode = 1'b0;
    wr(8'h0c, 8'h06);
    wdog_enable = 1'b1;
    for (i = 0; i < 300 && irq !== 1'b1; i = i + 1) cyc(1);
    // 200-cycle period, then one stage each for the flag and irq
    chk("wdog delay", 8'hca, i[7:0]);
    wdog_enable = 1'b0;
    rd(8'h05, 8'h08);
    rd(8'h05, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    print_verdict;
  end
endmodule
